// ==== src/jh_params.svh ====
// Purpose: Constants of the job handshake and slot allocator
// Assumes: 40 MHz system clock
// Notes:   Definitions only
`ifndef JH_PARAMS_SVH
`define JH_PARAMS_SVH
`define JH_CLK_HZ      40000000
`define JH_STARTUP_S   25
`define JH_WDOG_S      30
`define JH_NJOB        48
`define JH_NSLOT       64
`define JH_JOB_W       6
`define JH_CNT_W       7
`define JH_CODE_W      16
`define JH_TMR_W       31
`define JH_PREV_RST    48'hFFFF_FFFF_FFFF
`define JH_VEC_RST     48'h0000_0000_0000
`define JH_REG_CMD     4'h0
`define JH_REG_STAT    4'h4
`define JH_REG_CODE    4'h8
`define JH_CMD_GO_BIT  8
`define JH_ST_BUSY_BIT 0
`define JH_ST_DONE_BIT 1
`define JH_ST_WDOG_BIT 2
`define JH_ST_JOB_LSB  8
`endif

// ==== src/jh_pkg.sv ====
// Purpose: Types shared by both ends of the job handshake
// Assumes: jh_params.svh supplies the sizes
// Notes:   State of each module is one packed struct
`default_nettype none
`include "jh_params.svh"
package jh_pkg;
   typedef enum logic [2:0] {
      JH_K_UDP_SRV, JH_K_TCP_SRV, JH_K_TCP_CONN, JH_K_SERIAL,
      JH_K_OTHER, JH_K_BCAST, JH_K_UDP_CLI
   } jh_kind_t;

   typedef struct packed {
      logic [`JH_NJOB-1:0]   prev;
      logic [`JH_NJOB-1:0]   active;
      logic [`JH_NJOB-1:0]   done_pend;
      logic [`JH_NJOB-1:0]   tmo_pend;
      logic [`JH_NJOB-1:0]   start;
      logic [29:0]           boot_cnt;
      logic                  ready;
      logic                  stat_we;
      logic [`JH_JOB_W-1:0]  stat_job;
      logic [`JH_CODE_W-1:0] stat_code;
      logic [`JH_CNT_W-1:0]  slots_used;
      logic [`JH_JOB_W-1:0]  jobs_used;
      logic [`JH_CNT_W-1:0]  udp_max;
      logic [`JH_CNT_W-1:0]  udp_busy;
      logic                  grant;
      logic                  deny;
      logic                  drop;
   } jh_dev_st_t;

   typedef enum logic [1:0] {JH_IDLE, JH_WAIT_LOW, JH_RAISED, JH_RUN} jh_ctl_fsm_t;

   typedef struct packed {
      jh_ctl_fsm_t           fsm;
      logic [`JH_JOB_W-1:0]  job;
      logic [`JH_NJOB-1:0]   trig;
      logic [`JH_TMR_W-1:0]  wdog_cnt;
      logic                  done;
      logic                  wdog;
      logic [`JH_CODE_W-1:0] code;
      logic [31:0]           rdata;
   } jh_ctl_st_t;
endpackage
`default_nettype wire

// ==== src/jh_if.sv ====
// Purpose: Trigger, in-progress and status-word lines between controller and module
// Assumes: Both ends on clk_sys
// Notes:   Status write is one cycle, ahead of the in-progress fall
`timescale 1ns/10ps
`default_nettype none
`include "jh_params.svh"
interface jh_if;
   logic [`JH_NJOB-1:0]   controller_output_word;
   logic [`JH_NJOB-1:0]   module_input_word;
   logic                  stat_we;
   logic [`JH_JOB_W-1:0]  stat_job;
   logic [`JH_CODE_W-1:0] stat_code;

   modport dev (
      input  controller_output_word,
      output module_input_word,
      output stat_we,
      output stat_job,
      output stat_code
   );
   modport ctl (
      output controller_output_word,
      input  module_input_word,
      input  stat_we,
      input  stat_job,
      input  stat_code
   );
endinterface
`default_nettype wire

// ==== src/jh_dev.sv ====
// Purpose: Module end: trigger edge detect, in-progress bits, status write, slot pool
// Assumes: Inputs synchronous to clk_sys; job engine is outside on the user side
// Notes:   Release is applied before a request in the same cycle
//
// Contract
// - Launch only on trigger rising edge
// - On edge set in-progress and start job
// - Controller waits in-progress low before raising
// - Trigger already high never launches
// - Controller watchdog drops unanswered trigger
// - Controller watchdog preset thirty seconds
// - Module ignores triggers for startup time
// - Controller drops trigger once in-progress high
// - Write status before clearing in-progress
// - Clear in-progress only after trigger low
// - Timed-out transfer jobs clear regardless
// - Controller reads in-progress fall as done
// - Controller may rerun job any time
// - Shared pool of sixty-four slots
// - Datagram server takes max-client slots
// - Datagram clients beyond maximum are ignored
// - Stream server holds one slot idle
// - Each stream connection takes one slot
// - Closed connection returns its slot
// - Serial redirection takes one slot
// - Others one slot, broadcast receive none
// - At most forty-eight start-bit jobs
// - Reject requests beyond pool until freed
`timescale 1ns/10ps
`default_nettype none
`include "jh_params.svh"
module jh_dev
   import jh_pkg::*;
#(
   parameter int unsigned STARTUP_CYC = `JH_STARTUP_S * `JH_CLK_HZ
) (
   input  wire logic                  clk_sys,
   input  wire logic                  rst_b,
   jh_if.dev                          lnk,
   output logic [`JH_NJOB-1:0]        job_start,
   output logic                       dev_ready,
   input  wire logic                  job_done_valid,
   input  wire logic [`JH_JOB_W-1:0]  job_done_id,
   input  wire logic [`JH_CODE_W-1:0] job_done_code,
   input  wire logic                  job_done_tmo,
   input  wire logic                  slot_req_valid,
   input  wire jh_kind_t              slot_req_kind,
   input  wire logic [`JH_CNT_W-1:0]  slot_req_count,
   input  wire logic                  slot_req_start_bit,
   input  wire logic                  slot_rel_valid,
   input  wire jh_kind_t              slot_rel_kind,
   input  wire logic [`JH_CNT_W-1:0]  slot_rel_count,
   input  wire logic                  slot_rel_start_bit,
   output logic                       slot_grant,
   output logic                       slot_deny,
   output logic                       slot_drop,
   output logic [`JH_CNT_W-1:0]       slots_used,
   output logic [`JH_JOB_W-1:0]       jobs_used
);

   localparam logic [29:0]          BOOT_LAST = 30'(STARTUP_CYC - 1);
   localparam logic [7:0]           POOL      = 8'(`JH_NSLOT);
   localparam logic [`JH_JOB_W-1:0] JOB_MAX   = `JH_JOB_W'(`JH_NJOB);

   jh_dev_st_t s_r;
   jh_dev_st_t s_nxt;

   // Pool cost of one request of the given kind
   function automatic logic [`JH_CNT_W-1:0] jh_slot_cost(
      input jh_kind_t             kind,
      input logic [`JH_CNT_W-1:0] count
   );
      logic [`JH_CNT_W-1:0] c;
      c = `JH_CNT_W'h1;
      unique case (kind)
         JH_K_UDP_SRV:  c = count;
         JH_K_TCP_SRV:  c = `JH_CNT_W'h1;
         JH_K_TCP_CONN: c = `JH_CNT_W'h1;
         JH_K_SERIAL:   c = `JH_CNT_W'h1;
         JH_K_OTHER:    c = `JH_CNT_W'h1;
         JH_K_BCAST:    c = `JH_CNT_W'h0;
         JH_K_UDP_CLI:  c = `JH_CNT_W'h0;
         default:       c = `JH_CNT_W'h1;
      endcase
      return c;
   endfunction

   always_comb begin
      logic [`JH_NJOB-1:0]  edge_v;
      logic [`JH_NJOB-1:0]  launch;
      logic [`JH_NJOB-1:0]  clr;
      logic [`JH_CNT_W-1:0] cost;
      logic [7:0]           want;
      edge_v = '0;
      launch = '0;
      clr    = '0;
      cost   = '0;
      want   = '0;
      s_nxt  = s_r;
      s_nxt.start   = '0;
      s_nxt.stat_we = 1'b0;
      s_nxt.grant   = 1'b0;
      s_nxt.deny    = 1'b0;
      s_nxt.drop    = 1'b0;

      // Startup: edges seen before ready are consumed, not queued
      if (!s_r.ready) begin
         s_nxt.boot_cnt = s_r.boot_cnt + 30'h1;
         if (s_r.boot_cnt == BOOT_LAST) begin
            s_nxt.ready = 1'b1;
         end
      end

      // Prev resets high so a trigger found high at recovery is no edge
      edge_v     = lnk.controller_output_word & ~s_r.prev;
      s_nxt.prev = lnk.controller_output_word;
      if (s_r.ready) begin
         launch = edge_v & ~s_r.active;
      end
      s_nxt.start  = launch;
      s_nxt.active = s_r.active | launch;

      // Pending completions: status already written one cycle earlier
      clr = s_r.done_pend & (~lnk.controller_output_word | s_r.tmo_pend);
      s_nxt.active    = s_nxt.active & ~clr;
      s_nxt.done_pend = s_r.done_pend & ~clr;
      s_nxt.tmo_pend  = s_r.tmo_pend & ~clr;

      if (job_done_valid && (job_done_id < JOB_MAX)) begin
         if (s_r.active[job_done_id] && !s_r.done_pend[job_done_id]) begin
            s_nxt.stat_we   = 1'b1;
            s_nxt.stat_job  = job_done_id;
            s_nxt.stat_code = job_done_code;
            s_nxt.done_pend[job_done_id] = 1'b1;
            s_nxt.tmo_pend[job_done_id]  = job_done_tmo;
         end
      end

      // Release first so a freed slot is usable in the same cycle
      if (slot_rel_valid) begin
         if (slot_rel_kind == JH_K_UDP_CLI) begin
            if (s_r.udp_busy != '0) begin
               s_nxt.udp_busy = s_r.udp_busy - `JH_CNT_W'h1;
            end
         end else begin
            cost = jh_slot_cost(slot_rel_kind, slot_rel_count);
            if (s_r.slots_used >= cost) begin
               s_nxt.slots_used = s_r.slots_used - cost;
               if (slot_rel_kind == JH_K_UDP_SRV && s_r.udp_max >= slot_rel_count) begin
                  s_nxt.udp_max = s_r.udp_max - slot_rel_count;
               end
            end
            if (slot_rel_start_bit && s_r.jobs_used != '0) begin
               s_nxt.jobs_used = s_r.jobs_used - `JH_JOB_W'h1;
            end
         end
      end

      if (slot_req_valid) begin
         if (slot_req_kind == JH_K_UDP_CLI) begin
            // Clients run inside the slots their server already holds
            if (s_nxt.udp_busy < s_nxt.udp_max) begin
               s_nxt.udp_busy = s_nxt.udp_busy + `JH_CNT_W'h1;
               s_nxt.grant    = 1'b1;
            end else begin
               s_nxt.drop = 1'b1;
            end
         end else begin
            cost = jh_slot_cost(slot_req_kind, slot_req_count);
            want = {1'b0, s_nxt.slots_used} + {1'b0, cost};
            if (want > POOL) begin
               s_nxt.deny = 1'b1;
            end else if (slot_req_start_bit && s_nxt.jobs_used >= JOB_MAX) begin
               s_nxt.deny = 1'b1;
            end else begin
               s_nxt.slots_used = want[`JH_CNT_W-1:0];
               s_nxt.grant      = 1'b1;
               if (slot_req_start_bit) begin
                  s_nxt.jobs_used = s_nxt.jobs_used + `JH_JOB_W'h1;
               end
               if (slot_req_kind == JH_K_UDP_SRV) begin
                  s_nxt.udp_max = s_nxt.udp_max + slot_req_count;
               end
            end
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         s_r            <= '0;
         s_r.prev       <= `JH_PREV_RST;
         s_r.active     <= `JH_VEC_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign lnk.module_input_word = s_r.active;
   assign lnk.stat_we           = s_r.stat_we;
   assign lnk.stat_job          = s_r.stat_job;
   assign lnk.stat_code         = s_r.stat_code;
   assign job_start             = s_r.start;
   assign dev_ready             = s_r.ready;
   assign slot_grant            = s_r.grant;
   assign slot_deny             = s_r.deny;
   assign slot_drop             = s_r.drop;
   assign slots_used            = s_r.slots_used;
   assign jobs_used             = s_r.jobs_used;

endmodule // jh_dev
`default_nettype wire

// ==== src/jh_ctl.sv ====
// Purpose: Controller end: runs one job handshake at a time on software order
// Assumes: Register port strobes one cycle long, read data the cycle after
// Notes:   Watchdog runs only while waiting for the in-progress answer
`timescale 1ns/10ps
`default_nettype none
`include "jh_params.svh"
module jh_ctl
   import jh_pkg::*;
#(
   parameter int unsigned WDOG_CYC = `JH_WDOG_S * `JH_CLK_HZ
) (
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   jh_if.ctl                lnk,
   input  wire logic [3:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_we,
   input  wire logic        reg_re,
   output logic [31:0]      reg_rdata
);

   localparam logic [`JH_TMR_W-1:0] WDOG_LAST = `JH_TMR_W'(WDOG_CYC - 1);
   localparam logic [`JH_JOB_W-1:0] JOB_MAX   = `JH_JOB_W'(`JH_NJOB);

   jh_ctl_st_t s_r;
   jh_ctl_st_t s_nxt;

   always_comb begin
      logic go;
      go    = reg_we && (reg_addr == `JH_REG_CMD) && reg_wdata[`JH_CMD_GO_BIT];
      s_nxt = s_r;
      s_nxt.rdata = 32'h0000_0000;

      unique case (s_r.fsm)
         JH_IDLE: begin
            // Any finished job may be started again from here
            if (go && (reg_wdata[`JH_JOB_W-1:0] < JOB_MAX)) begin
               s_nxt.job  = reg_wdata[`JH_JOB_W-1:0];
               s_nxt.done = 1'b0;
               s_nxt.wdog = 1'b0;
               s_nxt.fsm  = JH_WAIT_LOW;
            end
         end
         JH_WAIT_LOW: begin
            if (!lnk.module_input_word[s_r.job]) begin
               s_nxt.trig[s_r.job] = 1'b1;
               s_nxt.wdog_cnt      = '0;
               s_nxt.fsm           = JH_RAISED;
            end
         end
         JH_RAISED: begin
            if (lnk.module_input_word[s_r.job]) begin
               s_nxt.trig[s_r.job] = 1'b0;
               s_nxt.fsm           = JH_RUN;
            end else if (s_r.wdog_cnt == WDOG_LAST) begin
               // Dropping the trigger lets a later command raise it afresh
               s_nxt.trig[s_r.job] = 1'b0;
               s_nxt.wdog          = 1'b1;
               s_nxt.fsm           = JH_IDLE;
            end else begin
               s_nxt.wdog_cnt = s_r.wdog_cnt + `JH_TMR_W'h1;
            end
         end
         JH_RUN: begin
            if (!lnk.module_input_word[s_r.job]) begin
               s_nxt.done = 1'b1;
               s_nxt.fsm  = JH_IDLE;
            end
         end
      endcase

      if (lnk.stat_we && (lnk.stat_job == s_r.job) && (s_r.fsm != JH_IDLE)) begin
         s_nxt.code = lnk.stat_code;
      end

      if (reg_re) begin
         unique case (reg_addr)
            `JH_REG_STAT: begin
               s_nxt.rdata[`JH_ST_BUSY_BIT] = (s_r.fsm != JH_IDLE);
               s_nxt.rdata[`JH_ST_DONE_BIT] = s_r.done;
               s_nxt.rdata[`JH_ST_WDOG_BIT] = s_r.wdog;
               s_nxt.rdata[`JH_ST_JOB_LSB +: `JH_JOB_W] = s_r.job;
            end
            `JH_REG_CODE: s_nxt.rdata[`JH_CODE_W-1:0] = s_r.code;
            default:      s_nxt.rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         s_r     <= '0;
         s_r.fsm <= JH_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign lnk.controller_output_word = s_r.trig;
   assign reg_rdata                  = s_r.rdata;

endmodule // jh_ctl
`default_nettype wire

// ==== verification/jh_handshake_properties.sv ====
// Purpose: Interface checks between controller end and module end
// Assumes: One clock; controller runs one job at a time
// Notes:   Helper history registers stand in for per-bit past values
`timescale 1ns/10ps
`default_nettype none
`include "jh_params.svh"
module jh_handshake_properties #(
   parameter int unsigned STARTUP_CYC = 16
) (
   input wire logic                  clk_sys,
   input wire logic                  rst_b,
   input wire logic [`JH_NJOB-1:0]   controller_output_word,
   input wire logic [`JH_NJOB-1:0]   module_input_word,
   input wire logic                  stat_we,
   input wire logic [`JH_JOB_W-1:0]  stat_job,
   input wire logic [`JH_CODE_W-1:0] stat_code
);
   logic [`JH_NJOB-1:0] cow1_r, cow2_r, cow3_r, mip1_r, seen_r, new_on, gone;
   logic [31:0]         up_r;
   logic                up_ok;
   assign new_on = module_input_word & ~mip1_r;
   assign gone   = mip1_r & ~module_input_word;
   // Margin so a one-cycle later ready is not flagged
   assign up_ok  = up_r > STARTUP_CYC + 4;
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         {cow1_r, cow2_r, cow3_r, mip1_r, seen_r} <= '0;
         up_r <= '0;
      end else begin
         {cow1_r, cow2_r, cow3_r} <= {controller_output_word, cow1_r, cow2_r};
         mip1_r <= module_input_word;
         seen_r <= (seen_r & ~new_on) | (stat_we ? (`JH_NJOB'(1) << stat_job) : '0);
         up_r   <= up_r + {31'h0, up_r != 32'hFFFF_FFFF};
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   sequence seq_ack;
      ##[1:3] (module_input_word != '0);
   endsequence
   sequence seq_drop;
      ##[1:3] (controller_output_word == '0);
   endsequence
   AST_RESET_IDLE: assert property ($rose(rst_b) |-> module_input_word == '0 && !stat_we)
      else $error("in-progress or status active at reset release");
   AST_NO_EARLY: assert property (up_r < STARTUP_CYC |-> module_input_word == '0)
      else $error("job launched during startup");
   AST_RISE_ON_EDGE: assert property ((new_on & ~((cow1_r & ~cow2_r) | (cow2_r & ~cow3_r))) == '0)
      else $error("in-progress rose without trigger edge");
   AST_EDGE_LAUNCH: assert property (up_ok && $rose(|controller_output_word) |-> seq_ack)
      else $error("trigger edge not answered");
   AST_STATUS_FIRST: assert property ((gone & ~seen_r) == '0)
      else $error("in-progress fell before status write");
   AST_STAT_ACTIVE: assert property (stat_we |-> module_input_word[stat_job])
      else $error("status written for idle job");
   AST_FALL_TRIG_LOW: assert property ((gone & cow1_r) == '0)
      else $error("in-progress fell while trigger high");
   AST_RAISE_LOW: assert property ((controller_output_word & ~cow1_r & mip1_r) == '0)
      else $error("trigger raised while in-progress high");
   AST_DROP_AFTER_ACK: assert property ($rose(|module_input_word) |-> seq_drop)
      else $error("trigger not dropped after in-progress");
endmodule // jh_handshake_properties
`default_nettype wire

// ==== verification/plc_job_handshake_slot_alloc_tb.sv ====
// Purpose: Self-checking bench for both ends of the job handshake
// Assumes: Short startup and watchdog counts
// Notes:   Slot cases are table rows; handshake cases by hand
`timescale 1ns/10ps
`default_nettype none
`include "jh_params.svh"
module plc_job_handshake_slot_alloc_tb
   import jh_pkg::*;
   ;
   localparam int unsigned STARTUP = 16;
   localparam int unsigned WDOG    = 64;
   typedef struct packed {
      logic       rel;
      jh_kind_t   kind;
      logic [6:0] cnt;
      logic       sb;
      logic [6:0] rep;
      logic [2:0] res;
      logic [6:0] used;
   } jh_tb_row_t;
   logic        clk_sys, rst_b, dv, dtmo, qv, rv, sb, we, re, dev_ready, grant, deny, drop;
   logic [47:0] job_start;
   logic [5:0]  did, jobs_used;
   logic [15:0] dcode;
   logic [6:0]  cnt, slots_used;
   logic [3:0]  addr;
   logic [31:0] wdata, rdata, d;
   jh_kind_t    kind;
   int          error_cnt, n_tests;
   jh_tb_row_t  rows [17] = '{
      '{1'h0, JH_K_UDP_SRV, 7'h3C, 1'h0, 7'h01, 3'h1, 7'h3C},
      '{1'h0, JH_K_TCP_SRV, 7'h01, 1'h0, 7'h01, 3'h1, 7'h3D},
      '{1'h0, JH_K_TCP_CONN, 7'h01, 1'h0, 7'h03, 3'h1, 7'h40},
      '{1'h0, JH_K_TCP_CONN, 7'h01, 1'h0, 7'h01, 3'h2, 7'h40},
      '{1'h0, JH_K_BCAST, 7'h01, 1'h0, 7'h01, 3'h1, 7'h40},
      '{1'h1, JH_K_TCP_CONN, 7'h01, 1'h0, 7'h01, 3'h0, 7'h3F},
      '{1'h0, JH_K_TCP_CONN, 7'h01, 1'h0, 7'h01, 3'h1, 7'h40},
      '{1'h0, JH_K_UDP_CLI, 7'h01, 1'h0, 7'h3C, 3'h1, 7'h40},
      '{1'h0, JH_K_UDP_CLI, 7'h01, 1'h0, 7'h01, 3'h4, 7'h40},
      '{1'h1, JH_K_UDP_CLI, 7'h01, 1'h0, 7'h01, 3'h0, 7'h40},
      '{1'h0, JH_K_UDP_CLI, 7'h01, 1'h0, 7'h01, 3'h1, 7'h40},
      '{1'h1, JH_K_UDP_SRV, 7'h3C, 1'h0, 7'h01, 3'h0, 7'h04},
      '{1'h0, JH_K_OTHER, 7'h01, 1'h1, 7'h30, 3'h1, 7'h34},
      '{1'h0, JH_K_OTHER, 7'h01, 1'h1, 7'h01, 3'h2, 7'h34},
      '{1'h1, JH_K_OTHER, 7'h01, 1'h1, 7'h01, 3'h0, 7'h33},
      '{1'h0, JH_K_OTHER, 7'h01, 1'h1, 7'h01, 3'h1, 7'h34},
      '{1'h0, JH_K_SERIAL, 7'h01, 1'h0, 7'h01, 3'h1, 7'h35}};
   jh_if i_jh_if ();
   jh_dev #(.STARTUP_CYC(STARTUP)) i_jh_dev (.clk_sys(clk_sys), .rst_b(rst_b), .lnk(i_jh_if),
      .job_start(job_start), .dev_ready(dev_ready), .job_done_valid(dv), .job_done_id(did),
      .job_done_code(dcode), .job_done_tmo(dtmo), .slot_req_valid(qv), .slot_req_kind(kind),
      .slot_req_count(cnt), .slot_req_start_bit(sb), .slot_rel_valid(rv), .slot_rel_kind(kind),
      .slot_rel_count(cnt), .slot_rel_start_bit(sb), .slot_grant(grant), .slot_deny(deny),
      .slot_drop(drop), .slots_used(slots_used), .jobs_used(jobs_used));
   jh_ctl #(.WDOG_CYC(WDOG)) i_jh_ctl (.clk_sys(clk_sys), .rst_b(rst_b), .lnk(i_jh_if),
      .reg_addr(addr), .reg_wdata(wdata), .reg_we(we), .reg_re(re), .reg_rdata(rdata));
   jh_handshake_properties #(.STARTUP_CYC(STARTUP)) i_jh_handshake_properties (
      .clk_sys(clk_sys), .rst_b(rst_b), .stat_we(i_jh_if.stat_we),
      .controller_output_word(i_jh_if.controller_output_word),
      .module_input_word(i_jh_if.module_input_word),
      .stat_job(i_jh_if.stat_job), .stat_code(i_jh_if.stat_code));
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask
   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge clk_sys);
      we <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge clk_sys);
      we <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] v);
      @(posedge clk_sys);
      re <= 1'b1;
      addr <= a;
      @(posedge clk_sys);
      re <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic run_job(input logic [5:0] j, input logic [15:0] c, input logic t);
      int k;
      k = 0;
      wr(4'h0, 32'h0000_0100 | 32'(j));
      while (job_start[j] !== 1'b1 && k < 200) begin
         @(posedge clk_sys);
         #1 k++;
      end
      chk(32'(job_start[j]), 32'h1, "job start");
      @(posedge clk_sys);
      dv <= 1'b1;
      did <= j;
      dcode <= c;
      dtmo <= t;
      @(posedge clk_sys);
      dv <= 1'b0;
      dtmo <= 1'b0;
      repeat (8) @(posedge clk_sys);
      rd(4'h4, d);
      chk(d, (32'(j) << 8) | 32'h2, "status");
      rd(4'h8, d);
      chk(d, 32'(c), "code");
      chk(32'(i_jh_if.module_input_word[j]), 32'h0, "in-progress");
      $display("Test job %0d done", j);
   endtask
   task automatic slot_op(input jh_tb_row_t r);
      repeat (r.rep) begin
         @(posedge clk_sys);
         kind <= r.kind;
         cnt <= r.cnt;
         sb <= r.sb;
         if (r.rel) rv <= 1'b1;
         else qv <= 1'b1;
         @(posedge clk_sys);
         rv <= 1'b0;
         qv <= 1'b0;
         #1 chk(32'({drop, deny, grant}), 32'(r.res), "slot answer");
      end
      chk(32'(slots_used), 32'(r.used), "slots used");
   endtask
   initial begin
      {rst_b, dv, dtmo, qv, rv, sb, we, re, did, dcode, cnt, addr, wdata} = '0;
      kind = JH_K_OTHER;
      error_cnt = 0;
      n_tests = 0;
      repeat (10) @(posedge clk_sys);
      rst_b <= 1'b1;
      #1 chk(32'(dev_ready), 32'h0, "ready at reset");
      chk(32'(slots_used), 32'h0, "slots at reset");
      // Trigger raised before startup ends must be lost
      wr(4'h0, 32'h0000_0103);
      repeat (WDOG + 40) @(posedge clk_sys);
      rd(4'h4, d);
      chk(d, 32'h0000_0304, "watchdog");
      chk(32'(dev_ready), 32'h1, "ready");
      wr(4'h0, 32'h0000_0130);
      wr(4'hC, 32'hFFFF_FFFF);
      rd(4'h4, d);
      chk(d, 32'h0000_0304, "job out of range");
      rd(4'hC, d);
      chk(d, 32'h0, "unmapped");
      $display("Test startup done");
      // Nonzero code first so the later zero code must really be written
      run_job(6'h03, 16'h8001, 1'b0);
      run_job(6'h2F, 16'h0000, 1'b0);
      run_job(6'h05, 16'h0012, 1'b1);
      run_job(6'h05, 16'hFFFF, 1'b0);
      foreach (rows[i]) slot_op(rows[i]);
      chk(32'(jobs_used), 32'h30, "start-bit jobs");
      $display("Test slots done");
      @(posedge clk_sys);
      rst_b <= 1'b0;
      repeat (10) @(posedge clk_sys);
      rst_b <= 1'b1;
      #1 chk(32'(slots_used), 32'h0, "slots after reset");
      chk(32'(dev_ready), 32'h0, "ready after reset");
      $display("Test reset done");
      end_of_test();
   end
   initial begin
      repeat (5000) @(posedge clk_sys);
      error_cnt++;
      $display("MISMATCH at %0t: run timed out", $time);
      end_of_test();
   end
endmodule // plc_job_handshake_slot_alloc_tb
`default_nettype wire
